/* File: rtl/arpt_pkg.sv */
// Constants, register map and state type for the auto-reload PWM timer
// Contract
// - Overflow sets flag; irq when enable set
// - Reading control/status clears overflow flag
// - External clock: overflow after (256-reload) * 2^div events
// - Selected capture edge latches counter, sets flag
// - Capture blocked until capture data read
// - Capture irq pending while flag and enable
// - Halt: enabled capture edge raises wake
// - Clock select bit picks CPU or external
// - Divide field gives input over two-power
// - Count enable zero freezes prescaler and counter
// - Force reload loads counter; reads zero
// - Counter access reads live, writes counter
// - Overflow reloads counter, sets PWM overflow level
// - Output enable bits connect each PWM pin
// - Polarity zero: high while counter <= compare
// - Polarity change inverts output at once
// - Duty sets second edge; reload first
// - Capture status bits 7:6 read zero
// - Edge select: 0 falling, 1 rising
// - Capture irq enable bits per channel
// - Compare shadow copied from duty at overflow
// - Capture flag cleared by capture data read
// - Counter increments on prescaler output tick
// - Counter access write clears prescaler
package arpt_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DUTY3   = 8'h73;
    localparam logic [7:0] IDX_DUTY2   = 8'h74;
    localparam logic [7:0] IDX_DUTY1   = 8'h75;
    localparam logic [7:0] IDX_DUTY0   = 8'h76;
    localparam logic [7:0] IDX_OUTCTL  = 8'h77;
    localparam logic [7:0] IDX_CSR     = 8'h78;
    localparam logic [7:0] IDX_CAR     = 8'h79;
    localparam logic [7:0] IDX_ARR     = 8'h7a;
    localparam logic [7:0] IDX_ICCSR   = 8'h7b;
    localparam logic [7:0] IDX_ICR1    = 8'h7c;
    localparam logic [7:0] IDX_ICR2    = 8'h7d;

    // Control/status field positions
    localparam int CSR_EXTERNAL_CLOCK_SELECT  = 7;
    localparam int CSR_DIV_H = 6;
    localparam int CSR_DIV_L = 4;
    localparam int CSR_TCE   = 3;
    localparam int CSR_FORCE_RELOAD  = 2;
    localparam int CSR_OIE   = 1;
    localparam int CSR_OVF   = 0;

    // Counter value that overflows on the next tick
    localparam logic [7:0] CNT_TOP = 8'hff;

    // Full machine state
    typedef struct packed {
        logic            external_clock_select;       // Prescaler input select
        logic [2:0]      div;        // Clock divide select
        logic            count_enable;        // Count enable
        logic            overflow_irq_enable;        // Overflow irq enable
        logic            ovf;        // Overflow flag
        logic [7:0]      cnt;        // Counter
        logic [6:0]      presc;      // Prescaler
        logic [7:0]      arr;        // Reload value
        logic [3:0]      oe;         // Output enables
        logic [3:0]      pol;        // Channel polarity
        logic [3:0][7:0] duty;       // Duty registers
        logic [3:0][7:0] cmp;        // Compare shadows
        logic [1:0]      cs;         // Capture edge select
        logic [1:0]      cie;        // Capture irq enable
        logic [1:0]      cf;         // Capture flags
        logic [1:0][7:0] icr;        // Capture data
        logic            ext_s1;     // External clock sync stages
        logic            ext_s2;
        logic            ext_s3;
        logic [1:0]      cap_s1;     // Capture pin sync stages
        logic [1:0]      cap_s2;
        logic [1:0]      cap_s3;
        logic            wr_pend;    // Write data phase pending
        logic [7:0]      wr_idx;     // Index of pending write
        logic [31:0]     hrdata;     // Read data
        logic            hready;     // Ready out
        logic [3:0]      pwm;        // Pin levels
        logic [3:0]      pwm_oe;     // Pin enables
        logic            ovf_irq;    // Overflow request
        logic            cap_irq;    // Capture request
        logic            wake;       // Halt wake pulse
    } arpt_state_t;

    // Reset state: all zero except ready out
    localparam arpt_state_t ARPT_RESET = '{hready: 1'b1, default: '0};

endpackage : arpt_pkg

/* File: rtl/arpt_top.sv */
// Auto-reload PWM timer with capture, AHB-Lite register slave
`timescale 1ns/1ps
module arpt_top
    import arpt_pkg::*;
(
    input  wire logic        hclk,              // 40 MHz bus clock
    input  wire logic        hresetn,           // Async reset, active low
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        halt_mode,         // Processor in halt
    input  wire logic        ext_clock_pin,     // External prescaler clock
    input  wire logic [1:0]  capture_input_pin, // Capture pins
    output logic      [3:0]  pulse_output_pin,  // PWM levels
    output logic      [3:0]  pulse_output_oe,   // PWM pin drive enables
    output logic             ovf_irq,           // Overflow request
    output logic             cap_irq,           // Capture request
    output logic             wake_irq           // Halt wake pulse
);

    arpt_state_t s_q;        // Registered state
    arpt_state_t s_d;        // Next state

    logic        take;       // Address phase accepted
    logic        rd;         // Read accepted this cycle
    logic        mapped;     // Address is in the word window
    logic [7:0]  a_idx;      // Register index of address phase
    logic [7:0]  wd;         // Write data byte
    logic        ext_rise;   // External clock rising edge
    logic        in_tick;    // Prescaler input tick
    logic        run;        // Prescaler advances
    logic        cnt_tick;   // Prescaler output tick
    logic        ovf_ev;     // Counter overflow event
    logic [1:0]  cap_ev;     // Selected capture edges
    logic [1:0]  cap_clr;    // Capture data being read

    // Mask of prescaler bits below the selected tap
    function automatic logic [6:0] tap_mask(input logic [2:0] n);
        tap_mask = 7'(8'hff >> (4'd8 - {1'b0, n}));
    endfunction : tap_mask

    // Read value of a register; side effects are handled elsewhere
    function automatic logic [7:0] read_reg(input logic [7:0] idx, input arpt_state_t s);
        case (idx)
            IDX_DUTY3:  read_reg = s.duty[3];
            IDX_DUTY2:  read_reg = s.duty[2];
            IDX_DUTY1:  read_reg = s.duty[1];
            IDX_DUTY0:  read_reg = s.duty[0];
            IDX_OUTCTL: read_reg = {s.oe, s.pol};
            // Force reload always reads zero
            IDX_CSR:    read_reg = {s.external_clock_select, s.div, s.count_enable, 1'b0, s.overflow_irq_enable, s.ovf};
            IDX_CAR:    read_reg = s.cnt;
            IDX_ARR:    read_reg = s.arr;
            IDX_ICCSR:  read_reg = {2'b00, s.cs, s.cie, s.cf};
            IDX_ICR1:   read_reg = s.icr[0];
            IDX_ICR2:   read_reg = s.icr[1];
            default:    read_reg = 8'h00;
        endcase
    endfunction : read_reg

    // All next-state logic
    always_comb begin
        s_d = s_q;

        // Two-flop synchronisers, third stage only for edge detection
        s_d.ext_s1 = ext_clock_pin;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_s3 = s_q.ext_s2;
        s_d.cap_s1 = capture_input_pin;
        s_d.cap_s2 = s_q.cap_s1;
        s_d.cap_s3 = s_q.cap_s2;
        ext_rise   = s_q.ext_s2 & ~s_q.ext_s3;

        // Address phase: single word transfers, narrow sizes treated alike
        take   = hsel & htrans[1] & hready;
        mapped = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'b00);
        a_idx  = mapped ? haddr[9:2] : 8'h00;
        rd     = take & ~hwrite;
        s_d.hready  = 1'b1;
        s_d.hrdata  = rd ? {24'h0, read_reg(a_idx, s_q)} : 32'h0;
        s_d.wr_pend = take & hwrite;
        s_d.wr_idx  = a_idx;
        wd          = hwdata[7:0];

        // Prescaler input: CPU clock or synchronised external edge
        in_tick = s_q.external_clock_select ? ext_rise : 1'b1;
        // Nothing counts in halt; the external clock is dead there anyway
        run = s_q.count_enable & in_tick & ~halt_mode;
        // Tap n fires once per 2^n input ticks
        cnt_tick = run & ((s_q.presc & tap_mask(s_q.div)) == tap_mask(s_q.div));
        ovf_ev   = cnt_tick & (s_q.cnt == CNT_TOP);

        if (run) begin
            s_d.presc = s_q.presc + 7'h01;
        end
        if (cnt_tick) begin
            if (ovf_ev) begin
                // Reload; so 256 - reload ticks per period
                s_d.cnt = s_q.arr;
                s_d.cmp = s_q.duty;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end

        // Data phase writes win over counting in the same cycle
        if (s_q.wr_pend) begin
            case (s_q.wr_idx)
                IDX_DUTY3:  s_d.duty[3] = wd;
                IDX_DUTY2:  s_d.duty[2] = wd;
                IDX_DUTY1:  s_d.duty[1] = wd;
                IDX_DUTY0:  s_d.duty[0] = wd;
                IDX_OUTCTL: begin
                    s_d.oe  = wd[7:4];
                    s_d.pol = wd[3:0];
                end
                IDX_CSR: begin
                    s_d.external_clock_select = wd[CSR_EXTERNAL_CLOCK_SELECT];
                    s_d.div  = wd[CSR_DIV_H:CSR_DIV_L];
                    s_d.count_enable  = wd[CSR_TCE];
                    s_d.overflow_irq_enable  = wd[CSR_OIE];
                    if (wd[CSR_FORCE_RELOAD]) begin
                        s_d.cnt   = s_q.arr;
                        s_d.presc = 7'h00;
                    end
                end
                IDX_CAR: begin
                    s_d.cnt   = wd;
                    s_d.presc = 7'h00;
                end
                IDX_ARR:    s_d.arr = wd;
                IDX_ICCSR: begin
                    // Flags are hardware owned; writes ignore them
                    s_d.cs  = wd[5:4];
                    s_d.cie = wd[3:2];
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end

        // Overflow flag: read clears, a new overflow wins
        if (rd & (a_idx == IDX_CSR)) begin
            s_d.ovf = 1'b0;
        end
        if (ovf_ev) begin
            s_d.ovf = 1'b1;
        end

        // Capture channels
        cap_clr[0] = rd & (a_idx == IDX_ICR1);
        cap_clr[1] = rd & (a_idx == IDX_ICR2);
        for (int i = 0; i < 2; i++) begin
            cap_ev[i] = s_q.cs[i] ? (s_q.cap_s2[i] & ~s_q.cap_s3[i])
                                  : (~s_q.cap_s2[i] & s_q.cap_s3[i]);
            if (cap_clr[i]) begin
                s_d.cf[i] = 1'b0;
            end
            // Blocked while flagged, unless the blocking read is now
            if (cap_ev[i] & (~s_q.cf[i] | cap_clr[i])) begin
                s_d.icr[i] = s_q.cnt;
                s_d.cf[i]  = 1'b1;
            end
        end

        // Wake pulse on any enabled edge in halt
        s_d.wake = halt_mode & |(cap_ev & s_q.cie);

        // Requests as levels from the next flags
        s_d.ovf_irq = s_d.ovf & s_d.overflow_irq_enable;
        s_d.cap_irq = |(s_d.cf & s_d.cie);

        // Pins follow next counter, shadow and polarity, so no lag
        for (int i = 0; i < 4; i++) begin
            s_d.pwm[i] = (s_d.cnt <= s_d.cmp[i]) ^ s_d.pol[i];
        end
        s_d.pwm_oe = s_d.oe;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= ARPT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register, except hresp, which is tied low
    assign hrdata           = s_q.hrdata;
    assign hreadyout        = s_q.hready;
    assign hresp            = 1'b0;
    assign pulse_output_pin = s_q.pwm;
    assign pulse_output_oe  = s_q.pwm_oe;
    assign ovf_irq          = s_q.ovf_irq;
    assign cap_irq          = s_q.cap_irq;
    assign wake_irq         = s_q.wake;

endmodule : arpt_top

/* File: test/arpt_sva.sv */
// Port checker for the auto-reload PWM timer
`timescale 1ns/1ps
module arpt_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        halt_mode,
    input wire logic [3:0]  pulse_output_pin,
    input wire logic [3:0]  pulse_output_oe,
    input wire logic        ovf_irq,
    input wire logic        cap_irq,
    input wire logic        wake_irq
);
    logic        tk;   // Transfer taken at this edge
    logic [11:0] ph_q; // Data phase: read, write, low address
    assign tk = hsel & htrans[1] & hready;
    // Remember what the data phase holds; upper address bits are not checked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ph_q <= '0;
        else ph_q <= {tk & !hwrite, tk & hwrite, haddr[9:0]};
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read or write data phase at one byte address
    sequence s_rd(logic [9:0] a); ph_q[11] && ph_q[9:0] == a; endsequence
    sequence s_wr(logic [9:0] a); ph_q[10] && ph_q[9:0] == a; endsequence
    AST_OVF_IRQ: assert property (s_rd(10'h1e0) |-> (&hrdata[1:0]) == $past(ovf_irq))
        else $error("overflow request disagrees with flag and enable");
    AST_FORCE_RELOAD_ZERO: assert property (s_rd(10'h1e0) |-> !hrdata[2])
        else $error("force reload bit read as one");
    AST_RSV_ZERO: assert property (s_rd(10'h1ec) |-> hrdata[7:6] == 2'b00)
        else $error("reserved capture bits not zero");
    AST_CAP_IRQ: assert property (s_rd(10'h1ec) |-> (|(hrdata[3:2] & hrdata[1:0])) == $past(cap_irq))
        else $error("capture request disagrees with flags and enables");
    AST_OE: assert property (s_wr(10'h1dc) |=> pulse_output_oe == $past(hwdata[7:4]))
        else $error("pin enables do not follow output control");
    AST_WAKE: assert property (wake_irq |-> $past(halt_mode))
        else $error("wake pulse outside halt");
    AST_WAKE_CAP: assert property (wake_irq |-> cap_irq)
        else $error("wake pulse without capture request");
    AST_RESET: assert property ($rose(hresetn) |-> !ovf_irq && !cap_irq && pulse_output_oe == 4'h0)
        else $error("outputs not cleared by reset");
endmodule : arpt_sva
bind arpt_top arpt_sva i_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .hreadyout, .halt_mode, .pulse_output_pin, .pulse_output_oe, .ovf_irq, .cap_irq, .wake_irq);

/* File: test/arpt_far.sv */
// Far-side model: capture pins, external clock and PWM watcher
`timescale 1ns/1ps
module arpt_far (
    input wire logic       hclk,
    input wire logic [3:0] pulse_output_pin,
    output logic           ext_clock_pin,
    output logic [1:0]     capture_input_pin
);
    logic       ext_run = 1'b0; // Bench lets the clock run
    logic [2:0] ph_q = '0;      // External clock phase
    int         ext_cnt = 0;    // Rising edges sent
    initial capture_input_pin = 2'b00;
    // Period of eight cycles, low and still while stopped
    always @(posedge hclk) begin
        ph_q <= ph_q + 3'd1;
        ext_clock_pin <= ext_run & ph_q[2];
        if (ext_run && ph_q == 3'd4) ext_cnt <= ext_cnt + 1;
    end
    // Set one capture pin, held long enough for the synchroniser
    task automatic cap(input int ch, input logic lv);
        @(posedge hclk);
        capture_input_pin[ch] <= lv;
        repeat (6) @(posedge hclk);
    endtask : cap
    // High time and period in cycles, events per period; hangs are cut by the bench
    task automatic measure(input int ch, output int per, output int hi, output int ev);
        int e0;
        @(negedge hclk);
        while (pulse_output_pin[ch] !== 1'b0) @(negedge hclk);
        while (pulse_output_pin[ch] !== 1'b1) @(negedge hclk);
        e0 = ext_cnt;
        per = 0;
        while (pulse_output_pin[ch] === 1'b1) begin
            @(negedge hclk);
            per++;
        end
        hi = per;
        while (pulse_output_pin[ch] !== 1'b1) begin
            @(negedge hclk);
            per++;
        end
        ev = ext_cnt - e0;
    endtask : measure
endmodule : arpt_far

/* File: test/test_arpt_top.sv */
// Self-checking testbench for the auto-reload PWM timer
`timescale 1ns/1ps
module test_arpt_top;
    import arpt_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, halt_mode, rd_ph;
    logic        ext_clock_pin, ovf_irq, cap_irq, wake_irq;
    logic [1:0]  htrans, capture_input_pin;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [3:0]  pulse_output_pin, pulse_output_oe;
    logic [7:0]  expq[$]; // Expected read bytes, oldest first
    logic [7:0]  d, q;
    int          errors = 0, n_tests = 0, cyc = 0, per, hi, ev;
    arpt_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .halt_mode, .ext_clock_pin, .capture_input_pin, .pulse_output_pin,
        .pulse_output_oe, .ovf_irq, .cap_irq, .wake_irq);
    arpt_far i_far (.hclk, .pulse_output_pin, .ext_clock_pin, .capture_input_pin);
    // 40 MHz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic cmp(input logic [15:0] e, input logic [15:0] s, input string nm);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp
    // Requests, enables and levels once settled
    task automatic chk(input logic [9:0] e);
        @(negedge hclk);
        cmp(16'(e), {6'h0, ovf_irq, cap_irq, pulse_output_oe, pulse_output_pin}, "outputs");
    endtask : chk
    // One single AHB transfer; waits on ready in both phases
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] v);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h0, v};
        rd_ph <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_ph <= 1'b0;
        hsel <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        xfer(1'b1, idx, v);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expq.push_back(e);
        xfer(1'b0, idx, 8'h00);
    endtask : rd
    // Read data checked mid data phase against the oldest note
    always @(negedge hclk) begin
        if (rd_ph === 1'b1) begin
            q = expq.pop_front();
            cmp({8'h0, q}, hrdata[15:0], "hrdata");
            cmp(16'h0001, {14'h0, hresp, hreadyout}, "hresp_hreadyout");
        end
    end
    task automatic test_done();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    // A hang counts as a mismatch
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, halt_mode, rd_ph, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        void'($urandom(32'h5d2ffc46));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 8'h73; i <= 8'h7e; i++) rd(8'(i), 8'h00);
        wr(8'h7e, 8'hff);
        rd(8'h7e, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom());
            wr(8'(8'h73 + i), d);
            rd(8'(8'h73 + i), d);
        end
        // Duty 3..0 = ff, 00, fe, fd; reload fc
        for (int i = 0; i < 4; i++) wr(8'(8'h73 + i), 8'(32'hfd_fe_00_ff >> (8 * i)));
        wr(8'h7a, 8'hfc);
        wr(8'h78, 8'h36);
        rd(8'h78, 8'h32);
        rd(8'h79, 8'hfc);
        repeat (20) @(posedge hclk);
        rd(8'h79, 8'hfc);
        wr(8'h77, 8'hf0);
        chk(10'h0f0);
        wr(8'h77, 8'hf5);
        chk(10'h0f5);
        wr(8'h77, 8'h0f);
        chk(10'h00f);
        wr(8'h77, 8'hf0);
        wr(8'h78, 8'h0a);
        wait (ovf_irq === 1'b1);
        wr(8'h78, 8'h02);
        wr(8'h79, 8'hfd);
        chk(10'h2fb);
        rd(8'h79, 8'hfd);
        rd(8'h78, 8'h03);
        rd(8'h78, 8'h02);
        chk(10'h0fb);
        for (int n = 0; n < 8; n++) begin
            wr(8'h78, 8'(8'h08 | (n << 4)));
            i_far.measure(0, per, hi, ev);
            cmp(16'(4 << n), 16'(per), "period");
            cmp(16'(2 << n), 16'(hi), "high");
        end
        wr(8'h78, 8'h88);
        i_far.ext_run <= 1'b1;
        i_far.measure(0, per, hi, ev);
        cmp(16'd4, 16'(ev), "events");
        i_far.ext_run <= 1'b0;
        wr(8'h78, 8'h00);
        wr(8'h79, 8'h5a);
        wr(8'h7b, 8'h1c);
        i_far.cap(0, 1'b1);
        rd(8'h7b, 8'h1d);
        chk(10'h1fb);
        wr(8'h79, 8'h66);
        i_far.cap(0, 1'b0);
        i_far.cap(0, 1'b1);
        rd(8'h7c, 8'h5a);
        rd(8'h7b, 8'h1c);
        i_far.cap(1, 1'b1);
        rd(8'h7b, 8'h1c);
        i_far.cap(1, 1'b0);
        rd(8'h7b, 8'h1e);
        rd(8'h7d, 8'h66);
        halt_mode <= 1'b1;
        i_far.cap(0, 1'b0);
        fork
            i_far.cap(0, 1'b1);
            wait (wake_irq === 1'b1);
        join
        halt_mode <= 1'b0;
        rd(8'h7c, 8'h66);
        test_done();
    end
endmodule : test_arpt_top
